// >>> hdl/scf_engine.sv
// Serial shift engine: four clock formats, baud divider, select output,
// bidirectional data pin and mode fault. Pins arrive synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "scf_map.svh"
module scf_engine
  import scf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire scf_cfg_t cfg,
  input wire logic ctrl1_write,
  input wire logic status_read,
  input wire logic tx_write,
  input wire logic [7:0] tx_data,
  input wire logic rx_read,
  input wire logic sck_i,
  input wire logic mosi_i,
  input wire logic miso_i,
  input wire logic ss_b_i,
  output logic sck_o,
  output logic sck_oe,
  output logic mosi_o,
  output logic mosi_oe,
  output logic miso_o,
  output logic miso_oe,
  output logic ss_b_o,
  output logic ss_b_oe,
  output logic master_active,
  output logic bidir_oe_eff,
  output logic fault_flag,
  output logic receive_full_flag,
  output logic tx_empty,
  output logic busy,
  output logic [7:0] rx_data
);

  scf_state_t state;
  logic [7:0] shifter;
  logic [7:0] tx_buf;
  logic tx_full;
  logic sample_bit;
  logic [4:0] edge_cnt;
  logic [`SCF_DIV_W-1:0] div_cnt;
  logic sck_int;
  logic sck_prev;
  logic fault_seen;
  logic master_select_cleared;
  logic bidir_cleared;

  // The master has no separate lead-in state: select falls one cycle after
  // the load, and the first serial clock edge follows one half period later.
  // That half period is the lead required in both phase formats.
  // The tail state covers the last half period of a transfer. In phase-set
  // back-to-back mode it doubles as the first edge of the next byte, so the
  // serial clock keeps an even spacing across the byte boundary.
  // The lead state is kept in the type but is never entered.

  // Half period of the bit clock in bus cycles: (pre+1) * 2^(rate+1) / 2
  function automatic logic [`SCF_DIV_W-1:0] half_period(input logic [2:0] pre,
                                                        input logic [3:0] rate);
    logic [3:0] r;
    r = (rate > `SCF_RATE_MAX) ? `SCF_RATE_MAX : rate;
    half_period = `SCF_DIV_W'({9'h000, 1'b0, pre} + 12'h001) << r;
  endfunction

  // Output bit of the shifter in the chosen bit order
  function automatic logic out_bit(input logic [7:0] s, input logic lsb);
    out_bit = lsb ? s[0] : s[7];
  endfunction

  function automatic logic [7:0] shift_in(input logic [7:0] s, input logic lsb,
                                          input logic b);
    shift_in = lsb ? {b, s[7:1]} : {s[6:0], b};
  endfunction

  logic is_master;
  logic auto_ss;
  logic fault_now;
  logic slave_sel;
  logic sck_edge;
  logic odd_edge;
  logic data_in;
  logic hp_tick;

  assign is_master = cfg.master_select & ~master_select_cleared & ~fault_flag;
  assign auto_ss = is_master & cfg.select_output_enable & cfg.fault_detect_enable;
  // Fault only counted when select is an input, not while driving it
  assign fault_now = is_master & cfg.fault_detect_enable & ~cfg.select_output_enable
                     & ~ss_b_i;
  assign slave_sel = ~is_master & ~ss_b_i;
  assign sck_edge = ~is_master & slave_sel & ((sck_i ^ cfg.clock_polarity_sel)
                    != sck_prev);
  assign odd_edge = ~edge_cnt[0];
  // Bidirectional: master listens on its output pin, slave on its output pin
  assign data_in = cfg.bidir_pin_select ? (is_master ? mosi_i : miso_i)
                   : (is_master ? miso_i : mosi_i);
  assign hp_tick = (div_cnt == half_period(cfg.prescale_field, cfg.rate_field)
                    - `SCF_DIV_W'(1));

  // Unpolarised clock level seen at the slave pin, for edge detection
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_prev <= 1'b0;
    end else begin
      sck_prev <= sck_i ^ cfg.clock_polarity_sel;
    end
  end

  // Baud divider, held clear unless a master transfer is running
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= '0;
    end else if (!is_master || state == SCF_IDLE || hp_tick) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + `SCF_DIV_W'(1);
    end
  end

  // Transmit buffer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_buf <= 8'h00;
      tx_full <= 1'b0;
    end else if (tx_write) begin
      tx_buf <= tx_data;
      tx_full <= 1'b1;
    end else if (load_now ||
                 (state == SCF_TAIL && is_master && hp_tick && cfg.clock_phase_sel)) begin
      // Emptied when the byte is taken into the shifter, or lost to a fault in that same cycle;
      // clearing it earlier would lose a byte queued for back-to-back
      tx_full <= 1'b0;
    end
  end

  logic load_now;
  logic last_edge;
  assign load_now = tx_full & (state == SCF_IDLE) & (is_master | slave_sel);
  assign last_edge = (edge_cnt == `SCF_EDGES - 5'h01);

  // Sequencer, edge counter and shifter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= SCF_IDLE;
      edge_cnt <= 5'h00;
      shifter <= 8'h00;
      sample_bit <= 1'b0;
      sck_int <= 1'b0;
    end else if (fault_now || (!is_master && !slave_sel)) begin
      state <= SCF_IDLE;
      edge_cnt <= 5'h00;
      sck_int <= 1'b0;
    end else begin
      case (state)
        SCF_IDLE: begin
          if (load_now) begin
            shifter <= tx_buf;
            edge_cnt <= 5'h00;
            // Select falls next cycle; first edge one half period later
            state <= SCF_RUN;
          end
        end
        SCF_LEAD: begin
          if (hp_tick) begin
            state <= SCF_RUN;
          end
        end
        SCF_RUN: begin
          if (is_master ? hp_tick : sck_edge) begin
            edge_cnt <= edge_cnt + 5'h01;
            if (is_master) begin
              sck_int <= ~sck_int;
            end
            // Phase set: odd edges after the first shift, even sample; phase clear: odd sample, even shift
            if (odd_edge != cfg.clock_phase_sel) begin
              sample_bit <= data_in;
            end else if (edge_cnt != 5'h00) begin
              shifter <= shift_in(shifter, cfg.lsb_first_enable, sample_bit);
            end
            if (last_edge) begin
              if (cfg.clock_phase_sel) begin
                // Last shift follows the eighth sample by half a period as master, by one cycle as slave
                state <= SCF_TAIL;
              end else begin
                shifter <= shift_in(shifter, cfg.lsb_first_enable, sample_bit);
                state <= is_master ? SCF_TAIL : SCF_IDLE;
              end
            end
          end
        end
        SCF_TAIL: begin
          if (is_master ? hp_tick : 1'b1) begin
            shifter <= cfg.clock_phase_sel ?
                       shift_in(shifter, cfg.lsb_first_enable, sample_bit) : shifter;
            edge_cnt <= 5'h00;
            if (cfg.clock_phase_sel && tx_full && is_master) begin
              // This tick is also edge one of the next byte: no pause
              shifter <= tx_buf;
              sck_int <= ~sck_int;
              edge_cnt <= 5'h01;
              state <= SCF_RUN;
            end else begin
              state <= SCF_IDLE;
            end
          end
        end
        default: state <= SCF_IDLE;
      endcase
    end
  end

  logic done;
  logic [7:0] final_byte;
  assign done = (state == SCF_TAIL) && (is_master ? hp_tick : 1'b1);
  assign final_byte = cfg.clock_phase_sel ?
                      shift_in(shifter, cfg.lsb_first_enable, sample_bit) : shifter;

  // Receive buffer; a byte arriving while full is dropped
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_data <= 8'h00;
      receive_full_flag <= 1'b0;
    end else if (done && !receive_full_flag) begin
      rx_data <= final_byte;
      receive_full_flag <= 1'b1;
    end else if (rx_read) begin
      receive_full_flag <= 1'b0;
    end
  end

  // Mode fault flag with its read-then-write clear; a new fault wins over the clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_flag <= 1'b0;
      fault_seen <= 1'b0;
      master_select_cleared <= 1'b0;
      bidir_cleared <= 1'b0;
    end else if (fault_now) begin
      fault_flag <= 1'b1;
      fault_seen <= 1'b0;
      master_select_cleared <= 1'b1;
      bidir_cleared <= cfg.bidir_pin_select;
    end else begin
      if (status_read && fault_flag) begin
        fault_seen <= 1'b1;
      end
      if (ctrl1_write) begin
        master_select_cleared <= 1'b0;
        bidir_cleared <= 1'b0;
        if (fault_seen) begin
          fault_flag <= 1'b0;
          fault_seen <= 1'b0;
        end
      end
    end
  end

  // Pin drivers, all registered
  logic tx_bit;
  logic bidir_eff;
  assign tx_bit = out_bit(shifter, cfg.lsb_first_enable);
  assign bidir_eff = cfg.bidir_output_enable & ~bidir_cleared;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_o <= 1'b0;
      sck_oe <= 1'b0;
      mosi_o <= 1'b0;
      mosi_oe <= 1'b0;
      miso_o <= 1'b0;
      miso_oe <= 1'b0;
      ss_b_o <= 1'b1;
      ss_b_oe <= 1'b0;
      master_active <= `SCF_CTRL1_RST;
      bidir_oe_eff <= 1'b0;
      tx_empty <= 1'b1;
      busy <= 1'b0;
    end else begin
      sck_o <= sck_int ^ cfg.clock_polarity_sel;
      sck_oe <= is_master;
      mosi_o <= tx_bit;
      miso_o <= tx_bit;
      mosi_oe <= is_master & (~cfg.bidir_pin_select | bidir_eff);
      miso_oe <= slave_sel & ~fault_flag & (~cfg.bidir_pin_select | bidir_eff);
      ss_b_o <= (state == SCF_IDLE);
      ss_b_oe <= auto_ss;
      master_active <= is_master;
      bidir_oe_eff <= bidir_eff;
      tx_empty <= ~tx_full;
      busy <= (state != SCF_IDLE);
    end
  end

endmodule
`default_nettype wire

// >>> hdl/scf_map.svh
// Constants for the serial shift engine: timing, field widths, reset values.
// Assumes a 25 MHz bus clock; included by the package and the engine.
//
// Behaviour
// - Polarity select inverts the serial clock only; edge counting is unchanged.
// - A transfer is eight bit times; phase-set bit one starts at first edge.
// - Phase set: automatic select falls half period early, rises after bit eight.
// - Automatic select exists only as master with output and fault enables set.
// - Phase set: slave drives data on select low; first edge presents bit one.
// - Phase set: even edges sample, later odd edges shift in and present next.
// - Phase set: a byte queued during a transfer follows at once, select held low.
// - Phase clear: select falls at bit one start, rises half period after bit eight.
// - Phase clear: slave drives first bit at select fall; odd sample, even shift.
// - Baud generator runs on the bus clock; prescale divisor one to eight.
// - Rate field divides the prescaler output by a power of two, 2 to 512.
// - Bit rate is bus clock over (prescale+1) times two to (rate+1).
// - The divider runs only as master during a transfer, otherwise held off.
// - With automatic select, the pin is low in transfers, high idle; no faults.
// - Bidirectional mode uses one data pin: master output pin, or slave output pin.
// - Bidirectional output enable sets direction; the pin always feeds the shifter.
// - Master with fault detect: select input low sets the fault flag.
// - Fault detect off or slave mode: select never raises a fault.
// - A fault clears master mode, floats all pins, aborts and idles.
// - A fault in bidirectional master mode clears the bidirectional output enable.
// - Status read with fault set, then control one write, clears the fault.
// - Except as phase-clear slave, the byte goes to receive buffer after the eighth shift; receive-full sets.
// - Slave deselected mid-transfer idles, floats its output, ignores the clock.
`ifndef SCF_MAP_SVH
`define SCF_MAP_SVH
`define SCF_BITS 8
`define SCF_CNT_W 4
`define SCF_EDGES 5'h10
`define SCF_PRE_W 3
`define SCF_RATE_W 4
`define SCF_RATE_MAX 4'h8
`define SCF_DIV_W 13
`define SCF_CTRL1_RST 1'b0
`endif

// >>> hdl/scf_pkg.sv
// Types shared by the serial shift engine.
// Assumes scf_map.svh is on the include path.
`include "scf_map.svh"
package scf_pkg;
  typedef enum logic [1:0] {SCF_IDLE, SCF_LEAD, SCF_RUN, SCF_TAIL} scf_state_t;
  typedef struct packed {
    logic master_select;
    logic clock_polarity_sel;
    logic clock_phase_sel;
    logic lsb_first_enable;
    logic select_output_enable;
    logic fault_detect_enable;
    logic bidir_pin_select;
    logic bidir_output_enable;
    logic [`SCF_PRE_W-1:0] prescale_field;
    logic [`SCF_RATE_W-1:0] rate_field;
  } scf_cfg_t;
  typedef struct packed {
    logic o;
    logic oe;
  } scf_pin_t;
endpackage

// >>> test/scf_properties.sv
// Port checker for the serial shift engine: select, fault and bit timing.
// Bound to scf_engine; a single clock domain with active-low reset.
`timescale 1ns/1ps
`default_nettype none
module scf_properties
  import scf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire scf_cfg_t cfg,
  input wire logic busy,
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic ss_b_o,
  input wire logic ss_b_oe,
  input wire logic ss_b_i,
  input wire logic master_active,
  input wire logic bidir_oe_eff,
  input wire logic fault_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic ps;
  logic seen;
  logic [12:0] run;
  wire logic arm = cfg.master_select && cfg.fault_detect_enable && !cfg.select_output_enable;
  // Half period in bus cycles; rate values above 8 clamp
  wire logic [12:0] h = ({10'h000, cfg.prescale_field} + 13'h0001)
    << ((cfg.rate_field > 4'h8) ? 4'h8 : cfg.rate_field);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ps <= 1'b0;
      seen <= 1'b0;
      run <= 13'h0000;
    end else begin
      ps <= sck_o;
      if (!busy) begin
        seen <= 1'b0;
        run <= 13'h0000;
      end else if (sck_o != ps) begin
        seen <= 1'b1;
        run <= 13'h0001;
      end else begin
        run <= run + 13'h0001;
      end
    end
  end
  a_sck_idle_level: assert property (master_active && sck_oe && !busy && $past(!busy) &&
    $stable(cfg) |-> sck_o == cfg.clock_polarity_sel) else $error("sck off idle level");
  a_auto_select_only: assert property (ss_b_oe |->
    $past(cfg.master_select && cfg.select_output_enable && cfg.fault_detect_enable))
    else $error("select driven outside master auto mode");
  // The clock pin lags a polarity change by one cycle, so cfg must be settled
  a_select_low_active: assert property (ss_b_oe && $stable(cfg) &&
    sck_o != cfg.clock_polarity_sel |-> !ss_b_o) else $error("select high while clock active");
  a_select_idle_high: assert property (ss_b_oe && !busy && $past(!busy) &&
    $past(!busy, 2) |-> ss_b_o) else $error("select low while idle");
  a_fault_sets: assert property (arm && master_active && !ss_b_i |-> ##[1:3] fault_flag)
    else $error("mode fault not flagged");
  a_fault_never: assert property (!arm && $past(!arm) && $past(!arm, 2)
    |-> !$rose(fault_flag)) else $error("fault raised while disarmed");
  a_fault_floats: assert property ($rose(fault_flag) |-> ##[0:1]
    (!master_active && !sck_oe && !mosi_oe && !miso_oe && !busy))
    else $error("fault left pins driven");
  a_bidir_fault_oe: assert property ($rose(fault_flag) && cfg.bidir_pin_select
    |-> ##[0:1] !bidir_oe_eff) else $error("bidir enable kept on fault");
  a_master_miso_unused: assert property (master_active && $past(master_active)
    |-> !miso_oe) else $error("master drives slave data pin");
  a_bit_spacing: assert property (master_active && busy && seen && sck_o != ps
    |-> run == h) else $error("serial clock half period wrong");
endmodule
bind scf_engine scf_properties scf_properties_i (.clk, .rst_b, .cfg, .busy, .sck_o, .sck_oe,
  .mosi_oe, .miso_oe, .ss_b_o, .ss_b_oe, .ss_b_i, .master_active, .bidir_oe_eff, .fault_flag);
`default_nettype wire

// >>> test/scf_slave_model.sv
// Behavioural external slave, clock phase clear, most significant bit first.
// Its select and serial clock come from the master under test.
`timescale 1ns/1ps
`default_nettype none
module scf_slave_model #(
  parameter logic [7:0] REPLY = 8'hC1
) (
  input wire logic sck,
  input wire logic ss_b,
  input wire logic mosi,
  output logic miso,
  output logic [7:0] rx
);
  logic [7:0] sr;
  initial begin
    miso = 1'b0;
    rx = 8'h00;
    sr = REPLY;
  end
  always @(negedge ss_b) sr = REPLY;
  always @(posedge sck) if (!ss_b) rx = {rx[6:0], mosi};
  always @(negedge sck) if (!ss_b) sr = {sr[6:0], 1'b0};
  // Released line flips rather than holding, so a late sample cannot pass
  always @(ss_b or sr) miso = ss_b ? ~miso : sr[7];
endmodule
`default_nettype wire

// >>> test/testbench.sv
// Self-checking bench for the serial shift engine as a master.
// Drives inputs 1 ns after the rising edge; an external slave model answers.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import scf_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  scf_cfg_t cfg = {8'h8C, 3'h1, 4'h1};
  logic ctrl1_write = 1'b0, status_read = 1'b0, tx_write = 1'b0, rx_read = 1'b0;
  logic ss_drv = 1'b1;
  logic [7:0] tx_data = 8'h00;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_oe, ss_b_o, ss_b_oe, master_active;
  logic bidir_oe_eff, fault_flag, receive_full_flag, busy, miso_m, tx_empty;
  logic [7:0] rx_data, slave_rx;
  int n_fail = 0, comparisons = 0, cyc = 0;
  // Pull-up on select unless the engine drives it
  wire logic ss_w = ss_b_oe ? ss_b_o : ss_drv;
  scf_engine scf_engine_i (.clk, .rst_b, .cfg, .ctrl1_write, .status_read, .tx_write,
    .tx_data, .rx_read, .sck_i(sck_o), .mosi_i(mosi_o), .miso_i(miso_m), .ss_b_i(ss_w),
    .sck_o, .sck_oe, .mosi_o, .mosi_oe, .miso_o(), .miso_oe, .ss_b_o, .ss_b_oe,
    .master_active, .bidir_oe_eff, .fault_flag, .receive_full_flag, .tx_empty, .busy,
    .rx_data);
  scf_slave_model scf_slave_model_i (.sck(sck_o), .ss_b(ss_w), .mosi(mosi_o),
    .miso(miso_m), .rx(slave_rx));
  always #20 clk = ~clk;
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic setup(input logic [7:0] f, input logic [2:0] p, input logic [3:0] r);
    cfg = {f, p, r};
    tick(3);
  endtask
  task automatic send(input logic [7:0] d);
    tx_data = d;
    tx_write = 1'b1;
    tick();
    tx_write = 1'b0;
  endtask
  task automatic test_master_xfer;
    int i, lsb, n;
    for (lsb = 0; lsb < 2; lsb++) begin
      setup(lsb ? 8'h9C : 8'h8C, 3'h1, 4'h1);
      send(8'h35);
      for (i = 0; i < 100 && ss_b_o === 1'b1; i++) tick();
      n = 0;
      // Half period is (1+1) * 2 = 4 bus cycles from select fall to first edge
      for (i = 0; i < 100 && sck_o === cfg.clock_polarity_sel; i++) begin
        tick();
        n++;
      end
      chk("select lead", 8'h04, n[7:0]);
      for (i = 0; i < 2000 && receive_full_flag !== 1'b1; i++) tick();
      chk("rx byte", lsb ? 8'h83 : 8'hC1, rx_data);
      tick(4);
      chk("slave byte", lsb ? 8'hAC : 8'h35, slave_rx);
      chk("select idle", 8'h01, ss_b_o);
      chk("tx empty", 8'h01, tx_empty);
      rx_read = 1'b1;
      tick();
      rx_read = 1'b0;
    end
    $display("test master_xfer done");
  endtask
  task automatic test_back_to_back;
    int i, rises, fulls;
    logic prev;
    rises = 0;
    fulls = 0;
    prev = 1'b1;
    setup(8'hEC, 3'h0, 4'h0);
    send(8'h12);
    tick(3);
    send(8'h34);
    for (i = 0; i < 200; i++) begin
      rx_read = receive_full_flag === 1'b1 && rx_read === 1'b0;
      if (rx_read) fulls++;
      if (ss_b_o === 1'b1 && prev === 1'b0) rises++;
      prev = ss_b_o;
      tick();
    end
    rx_read = 1'b0;
    chk("select rises", 8'h01, rises[7:0]);
    chk("bytes done", 8'h02, fulls[7:0]);
    $display("test back_to_back done");
  endtask
  task automatic test_mode_fault;
    setup(8'h87, 3'h0, 4'h0);
    send(8'h5A);
    tick(4);
    ss_drv = 1'b0;
    tick(4);
    chk("fault", 8'h01, fault_flag);
    chk("master", 8'h00, master_active);
    chk("pin enables", 8'h00, {sck_oe, mosi_oe, miso_oe, busy});
    chk("bidir enable", 8'h00, bidir_oe_eff);
    ss_drv = 1'b1;
    status_read = 1'b1;
    tick();
    status_read = 1'b0;
    ctrl1_write = 1'b1;
    tick();
    ctrl1_write = 1'b0;
    tick(2);
    chk("fault cleared", 8'h00, fault_flag);
    chk("master again", 8'h01, master_active);
    setup(8'h83, 3'h0, 4'h0);
    ss_drv = 1'b0;
    tick(4);
    chk("no fault", 8'h00, fault_flag);
    ss_drv = 1'b1;
    $display("test mode_fault done");
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  initial begin
    tick(10);
    rst_b = 1'b1;
    tick(2);
    test_master_xfer();
    test_back_to_back();
    test_mode_fault();
    tally_and_finish();
  end
endmodule
`default_nettype wire
